/* core/stp_pkg.sv */
// Shared timer prescaler package: register map, field positions, selects.
// Assumes an 8-bit I/O register port on the system clock.
package stp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STP_GTC_DATA_ADDR = 8'h43;
  localparam logic [7:0] STP_IO_OFFSET     = 8'h20;
  localparam logic [7:0] STP_GTC_IO_ADDR   = 8'h43 - 8'h20;
  localparam logic [7:0] STP_GTC_RESET     = 8'h00;
  localparam int         STP_HOLD_BIT      = 7;
  localparam int         STP_ASYNC_BIT     = 1;
  localparam int         STP_SYNC_BIT      = 0;

  // ----------------------------------------------------------------
  // Clock select codes and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [2:0] STP_CS_STOP  = 3'h0;
  localparam logic [2:0] STP_CS_DIRECT = 3'h1;
  localparam logic [2:0] STP_CS_DIV8  = 3'h2;
  localparam logic [2:0] STP_CS_DIV64 = 3'h3;
  localparam logic [2:0] STP_CS_DIV256 = 3'h4;
  localparam logic [2:0] STP_CS_DIV1024 = 3'h5;
  localparam logic [2:0] STP_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] STP_CS_EXT_RISE = 3'h7;
  localparam int         STP_PRESC_W  = 10;
  localparam int         STP_DIV8_LOG = 3;
  localparam int         STP_DIV64_LOG = 6;
  localparam int         STP_DIV256_LOG = 8;
  localparam int         STP_DIV1024_LOG = 10;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stp_reg_req_t;

  // Divided ticks, one per 8, 64, 256 or 1024 cycles each
  typedef struct packed {
    logic div8;
    logic div64;
    logic div256;
    logic div1024;
  } stp_taps_t;

endpackage : stp_pkg

/* core/stp_pin_edge.sv */
// External count pin synchroniser and edge detector.
// Assumes pin_i is asynchronous to core_clk_i.
`timescale 1ns/1ps
module stp_pin_edge
  import stp_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       pin_i,
  input  wire logic [2:0] clock_select_field_i,
  output logic            tick_o
);

  // ----------------------------------------------------------------
  // Sampling latch, three-flop chain, edge detect
  // ----------------------------------------------------------------
  logic       latch_q;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       tick;

  // latch when high
  // Non-blocking, so the first flop takes the value held before the edge
  always_latch
  begin
    if (core_clk_i)
    begin
      latch_q <= pin_i;
    end
  end

  always_comb
  begin
    sync_next = {sync_reg[1:0], latch_q};
    tick      = 1'b0;
    // rising or falling edge
    // Stage three keeps the old level; a further stage would break latency
    if (sync_reg[1] != sync_reg[2])
    begin
      if (clock_select_field_i == STP_CS_EXT_RISE)
      begin
        tick = sync_reg[1];
      end
      else if (clock_select_field_i == STP_CS_EXT_FALL)
      begin
        tick = ~sync_reg[1];
      end
    end
  end

  // edge to count in 2.5 to 3.5 cycles
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sync_reg <= 3'h0;
    end
    else if (clk_en_i)
    begin
      sync_reg <= sync_next;
    end
  end

  assign tick_o = tick & clk_en_i;

endmodule : stp_pin_edge

/* core/stp_prescaler.sv */
// Shared prescaler and clock selection for two timers.
// Assumes one-cycle register strobes and timers on the same clock.
// How it works
// - Select code one ticks the timer on every system clock cycle with the clock enable high.
// - Taps divide the system clock by 8, 64, 256 and 1024.
// - One free-running counter serves both timers, each choosing its tap.
// - Enabling a tap does not reset phase; first tick within N+1 cycles.
// - A prescaler reset restarts the phase for both timers.
// - Count pins are sampled each cycle, then edge detected.
// - Code seven ticks on rising edges, code six on falling edges.
// - Synchroniser flops on rising edge behind a clock-high latch.
// - Pin edge to tick takes 2.5 to 3.5 cycles.
// - Pin ticks bypass the prescaler divider.
// - While hold bit set, both reset bits keep their written value.
// - Clearing the hold bit clears the sync bit; the async bit waits for done in async mode.
// - Async reset bit resets third prescaler; self-clears unless held.
// - Sync reset bit resets shared prescaler; self-clears unless held.
// - Register answers at data address 0x43 and I/O address 0x23.
`timescale 1ns/1ps
module stp_prescaler
  import stp_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                clk_en_i,
  input  wire stp_pkg::stp_reg_req_t reg_req_i,
  output logic [7:0]               reg_rdata_o,
  output logic                     reg_hit_o,
  input  wire logic [2:0]          clock_select_field_a_i,
  input  wire logic [2:0]          clock_select_field_b_i,
  input  wire logic                ext_count_pin_a_i,
  input  wire logic                ext_count_pin_b_i,
  input  wire logic                async_mode_i,
  input  wire logic                async_reset_done_i,
  output logic                     async_prescaler_reset_o,
  output logic                     sync_prescaler_reset_o,
  output logic                     timer_a_tick_o,
  output logic                     timer_b_tick_o
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic       hold_reg;
  logic       hold_next;
  logic       async_reg;
  logic       async_next;
  logic       sync_reg;
  logic       sync_next;
  logic       hit;
  logic       wr_hit;
  logic       async_set;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  assign hit = reg_req_i.io_space ? (reg_req_i.addr == STP_GTC_IO_ADDR)
                                  : (reg_req_i.addr == STP_GTC_DATA_ADDR);
  assign wr_hit = hit & reg_req_i.wr;
  assign async_set = wr_hit & reg_req_i.wdata[STP_ASYNC_BIT];

  always_comb
  begin
    hold_next  = hold_reg;
    async_next = async_reg;
    sync_next  = sync_reg;
    if (wr_hit)
    begin
      hold_next  = reg_req_i.wdata[STP_HOLD_BIT];
      async_next = async_reg | reg_req_i.wdata[STP_ASYNC_BIT];
      sync_next  = sync_reg | reg_req_i.wdata[STP_SYNC_BIT];
    end
    if (!hold_next)
    begin
      sync_next = 1'b0;
      // async clears when done
      // A fresh request wins over a done left from the previous reset
      if (!async_mode_i || (async_reset_done_i && !async_set))
      begin
        async_next = 1'b0;
      end
    end
    // Reads show a reset bit only while hold keeps it or the async bit waits for done
    rdata_next = 8'h00;
    if (hit && reg_req_i.rd)
    begin
      rdata_next[STP_HOLD_BIT]  = hold_reg;
      rdata_next[STP_ASYNC_BIT] = async_reg;
      rdata_next[STP_SYNC_BIT]  = sync_reg;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      hold_reg  <= 1'b0;
      async_reg <= 1'b0;
      sync_reg  <= 1'b0;
      rdata_reg <= STP_GTC_RESET;
    end
    else if (clk_en_i)
    begin
      hold_reg  <= hold_next;
      async_reg <= async_next;
      sync_reg  <= sync_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_hit_o   = hit;
  // Reset is asserted for the write cycle itself, so a one-shot is seen
  assign sync_prescaler_reset_o  = sync_reg | (wr_hit &
                                   reg_req_i.wdata[STP_SYNC_BIT]);
  assign async_prescaler_reset_o = async_reg | (wr_hit &
                                   reg_req_i.wdata[STP_ASYNC_BIT]);

  // ----------------------------------------------------------------
  // Free-running prescaler
  // ----------------------------------------------------------------
  logic [STP_PRESC_W-1:0] cnt_reg;
  logic [STP_PRESC_W-1:0] cnt_next;
  stp_taps_t              taps;

  always_comb
  begin
    if (sync_prescaler_reset_o)
    begin
      cnt_next = '0;
    end
    else
    begin
      cnt_next = cnt_reg + STP_PRESC_W'(1);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
    end
    else if (clk_en_i)
    begin
      cnt_reg <= cnt_next;
    end
  end

  always_comb
  begin
    taps.div8    = clk_en_i & ~sync_prescaler_reset_o &
                   (&cnt_reg[STP_DIV8_LOG-1:0]);
    taps.div64   = clk_en_i & ~sync_prescaler_reset_o &
                   (&cnt_reg[STP_DIV64_LOG-1:0]);
    taps.div256  = clk_en_i & ~sync_prescaler_reset_o &
                   (&cnt_reg[STP_DIV256_LOG-1:0]);
    taps.div1024 = clk_en_i & ~sync_prescaler_reset_o &
                   (&cnt_reg[STP_DIV1024_LOG-1:0]);
  end

  // ----------------------------------------------------------------
  // Per-timer source selection
  // ----------------------------------------------------------------
  logic [1:0] pin_tick;
  logic [1:0] tick;
  logic [2:0] cs [2];
  logic [1:0] pins;

  assign cs[0] = clock_select_field_a_i;
  assign cs[1] = clock_select_field_b_i;
  assign pins  = {ext_count_pin_b_i, ext_count_pin_a_i};

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_timer
      stp_pin_edge u_edge (
        .core_clk_i           (core_clk_i),
        .rst_i                (rst_i),
        .clk_en_i             (clk_en_i),
        .pin_i                (pins[g]),
        .clock_select_field_i (cs[g]),
        .tick_o               (pin_tick[g])
      );

      always_comb
      begin
        case (cs[g])
          STP_CS_DIRECT:   tick[g] = clk_en_i;
          STP_CS_DIV8:     tick[g] = taps.div8;
          STP_CS_DIV64:    tick[g] = taps.div64;
          STP_CS_DIV256:   tick[g] = taps.div256;
          STP_CS_DIV1024:  tick[g] = taps.div1024;
          STP_CS_EXT_FALL: tick[g] = pin_tick[g];
          STP_CS_EXT_RISE: tick[g] = pin_tick[g];
          default:         tick[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  assign timer_a_tick_o = tick[0];
  assign timer_b_tick_o = tick[1];

endmodule : stp_prescaler

/* dv/stp_prescaler_asserts.sv */
// Port checker for the shared prescaler.
// Assumes the clock enable stays high across the tick windows checked.
`timescale 1ns/1ps
module stp_prescaler_asserts
  import stp_pkg::*;
(
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  input wire logic                  clk_en_i,
  input wire stp_pkg::stp_reg_req_t reg_req_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  reg_hit_o,
  input wire logic [2:0]            clock_select_field_a_i,
  input wire logic [2:0]            clock_select_field_b_i,
  input wire logic                  ext_count_pin_a_i,
  input wire logic                  ext_count_pin_b_i,
  input wire logic                  async_mode_i,
  input wire logic                  async_reset_done_i,
  input wire logic                  async_prescaler_reset_o,
  input wire logic                  sync_prescaler_reset_o,
  input wire logic                  timer_a_tick_o,
  input wire logic                  timer_b_tick_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic wr_hit;
  logic a_div8;
  assign wr_hit = reg_req_i.wr && reg_hit_o && clk_en_i;
  assign a_div8 = clk_en_i && !sync_prescaler_reset_o
                  && clock_select_field_a_i == STP_CS_DIV8;
  chk_direct_tick: assert property (
    clk_en_i && clock_select_field_a_i == STP_CS_DIRECT |-> timer_a_tick_o)
    else $error("direct select gave no tick");
  chk_div8_first: assert property (
    sync_prescaler_reset_o && clk_en_i ##1 a_div8 [*8] |-> timer_a_tick_o)
    else $error("first divide by 8 tick late or missing");
  chk_hold_keep: assert property (
    wr_hit && reg_req_i.wdata[7] && reg_req_i.wdata[0]
    |=> sync_prescaler_reset_o [*4])
    else $error("held reset bit dropped");
  chk_hold_clear: assert property (
    wr_hit && reg_req_i.wdata == 8'h00
    |=> !sync_prescaler_reset_o && !async_prescaler_reset_o)
    else $error("reset bits not cleared on hold release");
  chk_sync_pulse: assert property (
    wr_hit && reg_req_i.wdata == 8'h01
    |-> sync_prescaler_reset_o ##1 !sync_prescaler_reset_o)
    else $error("sync reset not a single cycle");
  chk_async_wait: assert property (
    async_prescaler_reset_o && async_mode_i && !async_reset_done_i
    |=> async_prescaler_reset_o)
    else $error("async reset dropped before done");
  chk_ext_fall: assert property (
    $fell(ext_count_pin_a_i) && clk_en_i
    && clock_select_field_a_i == STP_CS_EXT_FALL |-> ##[2:3] timer_a_tick_o)
    else $error("pin edge tick outside latency");
  chk_ext_rise: assert property (
    $rose(ext_count_pin_b_i) && clk_en_i
    && clock_select_field_b_i == STP_CS_EXT_RISE |-> ##[2:3] timer_b_tick_o)
    else $error("rising pin edge gave no tick in time");
  chk_reg_map: assert property (
    reg_hit_o == (reg_req_i.io_space ? reg_req_i.addr == STP_GTC_IO_ADDR
                  : reg_req_i.addr == STP_GTC_DATA_ADDR))
    else $error("register decode wrong");
  cover property (wr_hit && reg_req_i.wdata[7]);
  cover property (async_prescaler_reset_o && async_reset_done_i);
  cover property (timer_b_tick_o && clock_select_field_b_i == 3'h7);
endmodule : stp_prescaler_asserts

bind stp_prescaler stp_prescaler_asserts u_chk (.core_clk_i, .rst_i,
  .clk_en_i, .reg_req_i, .reg_rdata_o, .reg_hit_o, .clock_select_field_a_i,
  .clock_select_field_b_i, .ext_count_pin_a_i, .ext_count_pin_b_i,
  .async_mode_i, .async_reset_done_i, .async_prescaler_reset_o,
  .sync_prescaler_reset_o, .timer_a_tick_o, .timer_b_tick_o);

/* dv/stp_pin_model.sv */
// Far side model: external count source and third prescaler.
// Assumes start_i is high for one rising edge per burst.
`timescale 1ns/1ps
module stp_pin_model
(
  input  wire logic       core_clk_i,
  input  wire logic       start_i,
  input  wire logic [3:0] pulses_i,
  input  wire logic [2:0] half_i,
  input  wire logic       reset_req_i,
  output logic            pin_o = 1'b0,
  output logic            done_o = 1'b0
);
  int n;
  int wait_cnt = 0;
  // half period three cycles or more
  always @(posedge core_clk_i)
  begin
    if (start_i)
    begin
      for (n = 0; n < 2 * pulses_i; n++)
      begin
        @(negedge core_clk_i);
        pin_o = ~pin_o;
        repeat ((half_i < 3 ? 3 : half_i) - 1) @(negedge core_clk_i);
      end
    end
  end
  always @(posedge core_clk_i)
  begin
    wait_cnt <= reset_req_i ? wait_cnt + 1 : 0;
    done_o   <= reset_req_i && wait_cnt >= 4;
  end
endmodule : stp_pin_model

/* dv/stp_prescaler_tb_top.sv */
// Self-checking bench for the shared prescaler.
// Assumes the pin model on both count pins and the bound checker.
`timescale 1ns/1ps
module stp_prescaler_tb_top;
  import stp_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         rst_i      = 1'b1;
  logic         clk_en_i   = 1'b1;
  stp_reg_req_t req        = '0;
  logic [2:0]   cs_a       = 3'h0;
  logic [2:0]   cs_b       = 3'h0;
  logic         amode      = 1'b0;
  logic         start      = 1'b0;
  logic         rd_d       = 1'b0;
  logic [3:0]   pulses     = 4'h1;
  logic [2:0]   half       = 3'h3;
  logic [7:0]   rdata;
  logic         pin_a, pin_b, adone, ares, tick_a, tick_b, sres;
  logic [15:0]  ca, cb;
  logic [7:0]   exp_q[$];
  int           num_errors = 0;
  int           n_compared = 0;
  int           seed, i;
  int           sh[6] = '{0, 0, STP_DIV8_LOG, STP_DIV64_LOG,
                          STP_DIV256_LOG, STP_DIV1024_LOG};
  always #10 core_clk_i = ~core_clk_i;
  stp_prescaler u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .clk_en_i(clk_en_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_hit_o(), .clock_select_field_a_i(cs_a),
    .clock_select_field_b_i(cs_b), .ext_count_pin_a_i(pin_a),
    .ext_count_pin_b_i(pin_b), .async_mode_i(amode),
    .async_reset_done_i(adone), .async_prescaler_reset_o(ares),
    .sync_prescaler_reset_o(sres), .timer_a_tick_o(tick_a),
    .timer_b_tick_o(tick_b));
  stp_pin_model u_pin_a (.core_clk_i(core_clk_i), .start_i(start),
    .pulses_i(pulses), .half_i(half), .reset_req_i(ares), .pin_o(pin_a),
    .done_o(adone));
  stp_pin_model u_pin_b (.core_clk_i(core_clk_i), .start_i(start),
    .pulses_i(pulses), .half_i(half), .reset_req_i(1'b0), .pin_o(pin_b),
    .done_o());
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  // Reads note their expected byte; the monitor pops it a cycle later
  task automatic reg_op(input logic w, input logic io,
                        input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req = '{w, !w, io, a, d};
    if (!w)
      exp_q.push_back(d);
    @(negedge core_clk_i);
    req = '0;
  endtask : reg_op
  task automatic ticks(input int n, input int ea, input int eb);
    ca = '0;
    cb = '0;
    repeat (n)
    begin
      @(negedge core_clk_i);
      ca = ca + tick_a;
      cb = cb + tick_b;
    end
    check("tick_a", 16'(ea), ca);
    check("tick_b", 16'(eb), cb);
  endtask : ticks
  always @(posedge core_clk_i)
    rd_d <= req.rd && clk_en_i && !rst_i;
  always @(negedge core_clk_i)
  begin
    if (rd_d)
      check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
  end
  initial
  begin
    #(20 * 40000);
    num_errors++;
    close_out();
  end
  initial
  begin
    seed = 32'h2db7;
    repeat (3) @(negedge core_clk_i);
    rst_i = 1'b0;
    reg_op(0, 0, 8'h43, 8'h00);
    reg_op(1, 1, 8'h23, 8'hFF);
    reg_op(0, 0, 8'h43, 8'h83);
    reg_op(0, 1, 8'h43, 8'h00);
    cs_a = STP_CS_DIV8;
    cs_b = STP_CS_DIV8;
    ticks(32, 0, 0);
    check("sres", 16'h0001, {15'h0000, sres});
    reg_op(1, 0, 8'h43, 8'h00);
    ticks(5, 0, 0);
    ticks(5, 1, 1);
    for (i = 1; i < 6; i++)
    begin
      cs_a = 3'(i);
      cs_b = 3'(i == 5 ? 1 : i + 1);
      ticks(1024, 1024 >> sh[cs_a], 1024 >> sh[cs_b]);
    end
    cs_a = STP_CS_DIV8;
    cs_b = STP_CS_DIV8;
    repeat (1 + ($random(seed) & 7)) @(negedge core_clk_i);
    reg_op(1, 0, 8'h43, 8'h01);
    ticks(5, 0, 0);
    ticks(5, 1, 1);
    reg_op(0, 0, 8'h43, 8'h00);
    amode = 1'b1;
    reg_op(1, 0, 8'h43, 8'h02);
    reg_op(0, 0, 8'h43, 8'h02);
    repeat (12) @(negedge core_clk_i);
    reg_op(0, 0, 8'h43, 8'h00);
    amode = 1'b0;
    reg_op(1, 0, 8'h43, 8'h02);
    reg_op(0, 0, 8'h43, 8'h00);
    cs_a = STP_CS_DIRECT;
    clk_en_i = 1'b0;
    ticks(16, 0, 0);
    clk_en_i = 1'b1;
    ticks(16, 16, 2);
    for (i = 0; i < 2; i++)
    begin
      cs_a = i ? STP_CS_EXT_RISE : STP_CS_EXT_FALL;
      cs_b = i ? STP_CS_EXT_FALL : STP_CS_EXT_RISE;
      pulses = 4'(1 + ($random(seed) & 7));
      half = 3'(3 + ($random(seed) & 3));
      repeat (2) @(negedge core_clk_i);
      start = 1'b1;
      @(negedge core_clk_i);
      start = 1'b0;
      ticks(2 * pulses * half + 8, pulses, pulses);
    end
    close_out();
  end
endmodule : stp_prescaler_tb_top
